// File: logic/flash_interface_config_regs.sv
// configuration register bank of a serial nor flash: wishbone slave, pin muxing, latency and command gating
//
// Contract
// RQ1 - address-length bit chooses 3 address bytes when clear, 4 when set, reset 0
// RQ2 - four-wire protocol bit sends opcode, address and data on four lines
// RQ3 - any four-bit mode turns write-protect pin into line 2, reset pin into line 3
// RQ4 - line3 reset enabled in four-bit mode: line 3 low, select high resets
// RQ5 - without four-bit mode line 3 is a dedicated active-low reset input
// RQ6 - array latency field sets 0..15 dummy cycles for array and nv reads, default 8
// RQ7 - host picks array latency code that suits its serial clock rate
// RQ8 - continuous-read mode cycles come before dummy cycles, not counted in them
// RQ9 - host stays under 166 MHz single rate and 102 MHz double rate
// RQ10 - discoverable-parameter read uses 8 dummy cycles, unique id read uses 32
// RQ11 - with ecc reporting every array read returns at least two bytes
// RQ12 - host sets latency above zero for secure region read in 4-4-4
// RQ13 - two-bit volatile latency field sets dummy cycles of volatile register reads
// RQ14 - blank-check bit makes erase check sector first and abort when blank
// RQ15 - buffer-size bit picks 256 or 512 byte program buffer, overflow wraps
// RQ16 - layout bit picks hybrid or uniform sectors, volatile copy read-only
// RQ17 - 4KB erase 20h accepted only in hybrid layout, ignored in uniform
// RQ18 - command 30h clears status when bit clear, resumes suspended work when set
// RQ19 - legacy reset bit enables F0h software reset, otherwise F0h does nothing
// RQ20 - host writes reserved bits with zero
// RQ21 - quad-width bit: single-line opcode, data on four lines
// RQ22 - small-sector location bit puts 4KB block at bottom when 0, top when 1
// RQ23 - after reset volatile copies load from nonvolatile before transactions
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "flash_cfg_params.svh"
module flash_interface_config_regs
    import flash_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // serial pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic line3_reset_pin_i,
    // command engine
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_opcode_i,
    input wire logic dummy_start_i,
    input wire read_class_e read_class_i,
    input wire logic [3:0] mode_cycles_i,
    // controls and events
    output logic ready_o,
    output logic [2:0] addr_bytes_o,
    output logic four_wire_o,
    output logic quad_width_o,
    output logic line2_data_o,
    output logic line3_data_o,
    output logic write_protect_n_o,
    output logic hw_reset_o,
    output logic erase_blank_check_o,
    output logic [8:0] pbuf_mask_o,
    output logic uniform_sectors_o,
    output logic small_sector_top_o,
    output logic small_sector_split_o,
    output logic erase4k_go_o,
    output logic clear_status_o,
    output logic resume_o,
    output logic soft_reset_o,
    output logic dummy_done_o
);
    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [5:0] dummy_for(read_class_e cls, iflat_s f2, trbeh_s f3);
        logic [5:0] n;
        n = 6'd0;
        unique case (cls)
            RD_ARRAY, RD_NV_REG: n = {2'b00, f2.array_read_latency}; // RQ6
            RD_VOL_REG: n = vol_lat(f3.volatile_reg_latency); // RQ13
            RD_SFDP: n = `SFDP_DUMMY; // RQ10
            RD_UID: n = `UID_DUMMY; // RQ10
            default: n = 6'd0;
        endcase
        return n;
    endfunction : dummy_for

    function automatic logic [5:0] vol_lat(logic [1:0] code);
        logic [5:0] n;
        n = 6'd0;
        unique case (code)
            2'b00: n = 6'd0;
            2'b01: n = 6'd1;
            2'b10: n = 6'd1;
            2'b11: n = 6'd2;
        endcase
        return n;
    endfunction : vol_lat

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic sck_s;
    logic cs_n_s;
    logic wp_n_s;
    logic line3_s;

    pin_sync #(.WIDTH(4), .INIT(4'hf)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({sck_i, cs_n_i, wp_n_i, line3_reset_pin_i}),
        .sync_o({sck_s, cs_n_s, wp_n_s, line3_s})
    );

    // ----------------------------------------
    // register pairs
    // ----------------------------------------
    typedef enum logic {ST_LOAD, ST_RUN} load_e;
    load_e state_r;
    load_e state_nxt;
    logic load;
    logic acc;
    logic wr;
    logic [7:0] layout_nv;
    logic [7:0] layout_v;
    logic [7:0] iflat_nv;
    logic [7:0] iflat_v;
    logic [7:0] trbeh_nv;
    logic [7:0] trbeh_v;
    iflat_s f2;
    trbeh_s f3;
    logic quad_any;

    assign acc = cyc_i & stb_i & ~ack_o;
    assign wr = acc & we_i & sel_i[0];
    assign load = (state_r == ST_LOAD);
    assign f2 = iflat_s'(iflat_v);
    assign f3 = trbeh_s'(trbeh_v);
    assign quad_any = layout_v[`QUAD_BIT] | f2.four_wire_protocol_sel; // RQ3

    cfg_reg_pair #(.NV_RESET(`LAYOUT_RESET), .NV_WMASK(`LAYOUT_NV_WMASK), .V_WMASK(`LAYOUT_V_WMASK)) u_layout (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .nv_we_i(wr && adr_i == `OFS_LAYOUT_NV),
        .v_we_i(wr && adr_i == `OFS_LAYOUT_V),
        .load_i(load),
        .wdata_i(dat_i[7:0]),
        .nv_o(layout_nv),
        .v_o(layout_v)
    );

    cfg_reg_pair #(.NV_RESET(`IFLAT_RESET), .NV_WMASK(`IFLAT_NV_WMASK), .V_WMASK(`IFLAT_V_WMASK)) u_iflat (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .nv_we_i(wr && adr_i == `OFS_IFLAT_NV),
        .v_we_i(wr && adr_i == `OFS_IFLAT_V),
        .load_i(load),
        .wdata_i(dat_i[7:0]),
        .nv_o(iflat_nv),
        .v_o(iflat_v)
    );

    // volatile layout bit is read-only
    cfg_reg_pair #(.NV_RESET(`TRBEH_RESET), .NV_WMASK(`TRBEH_NV_WMASK), .V_WMASK(`TRBEH_V_WMASK)) u_trbeh (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .nv_we_i(wr && adr_i == `OFS_TRBEH_NV),
        .v_we_i(wr && adr_i == `OFS_TRBEH_V), // RQ16
        .load_i(load),
        .wdata_i(dat_i[7:0]),
        .nv_o(trbeh_nv),
        .v_o(trbeh_v)
    );

    // ----------------------------------------
    // reset sources and load sequencer
    // ----------------------------------------
    logic rst_req;
    logic line3_low_r;
    logic line3_low_nxt;
    logic soft_hit;

    // the pin reset fires on the falling level, once per assertion
    always_comb begin
        if (quad_any) begin
            line3_low_nxt = ~line3_s & cs_n_s & f2.line3_reset_enable; // RQ4
        end else begin
            line3_low_nxt = ~line3_s; // RQ5
        end
    end

    assign soft_hit = cmd_valid_i && state_r == ST_RUN && cmd_opcode_i == `OP_SOFT_RESET
                      && f3.legacy_soft_reset_enable; // RQ19
    assign rst_req = (line3_low_nxt & ~line3_low_r) | soft_hit;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_LOAD: state_nxt = ST_RUN; // RQ23
            ST_RUN: if (rst_req) begin
                state_nxt = ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_LOAD;
            line3_low_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            line3_low_r <= line3_low_nxt;
        end
    end

    // ----------------------------------------
    // wishbone read path
    // ----------------------------------------
    logic [31:0] dat_nxt;
    logic ack_nxt;
    logic dummy_busy_r;

    // unmapped addresses are acknowledged and read as zero
    always_comb begin
        ack_nxt = acc;
        dat_nxt = dat_o;
        if (acc && !we_i) begin
            unique case (adr_i)
                `OFS_LAYOUT_NV: dat_nxt = {24'h0, layout_nv};
                `OFS_LAYOUT_V: dat_nxt = {24'h0, layout_v};
                `OFS_IFLAT_NV: dat_nxt = {24'h0, iflat_nv};
                `OFS_IFLAT_V: dat_nxt = {24'h0, iflat_v};
                `OFS_TRBEH_NV: dat_nxt = {24'h0, trbeh_nv};
                `OFS_TRBEH_V: dat_nxt = {24'h0, trbeh_v};
                `OFS_STATUS: dat_nxt = {28'h0, dummy_busy_r, ~cs_n_s, quad_any, ready_o};
                default: dat_nxt = 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // dummy-cycle counter on serial clock edges
    // ----------------------------------------
    logic dummy_busy_nxt;
    logic [6:0] dummy_cnt_r;
    logic [6:0] dummy_cnt_nxt;
    logic sck_d_r;
    logic sck_rise;
    logic done_nxt;

    assign sck_rise = sck_s & ~sck_d_r;

    // mode cycles run ahead of the configured dummies, so both are summed
    always_comb begin
        dummy_busy_nxt = dummy_busy_r;
        dummy_cnt_nxt = dummy_cnt_r;
        done_nxt = 1'b0;
        if (dummy_start_i) begin
            dummy_busy_nxt = 1'b1;
            dummy_cnt_nxt = {3'b000, mode_cycles_i} + {1'b0, dummy_for(read_class_i, f2, f3)}; // RQ8
        end else if (dummy_busy_r) begin
            if (cs_n_s) begin
                dummy_busy_nxt = 1'b0;
            end else if (dummy_cnt_r == 7'd0) begin
                dummy_busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else if (sck_rise) begin
                dummy_cnt_nxt = dummy_cnt_r - 7'd1;
            end
        end
    end

    // ----------------------------------------
    // command gating and registered outputs
    // ----------------------------------------
    logic run_cmd;
    assign run_cmd = cmd_valid_i && state_r == ST_RUN;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
            ack_o <= 1'b0;
            dummy_busy_r <= 1'b0;
            dummy_cnt_r <= 7'd0;
            sck_d_r <= 1'b1;
            dummy_done_o <= 1'b0;
            ready_o <= 1'b0;
            addr_bytes_o <= `ADDR_BYTES_3;
            four_wire_o <= 1'b0;
            quad_width_o <= 1'b0;
            line2_data_o <= 1'b1;
            line3_data_o <= 1'b1;
            write_protect_n_o <= 1'b1;
            hw_reset_o <= 1'b0;
            erase_blank_check_o <= 1'b0;
            pbuf_mask_o <= `PBUF_MASK_256;
            uniform_sectors_o <= 1'b0;
            small_sector_top_o <= 1'b0;
            small_sector_split_o <= 1'b0;
            erase4k_go_o <= 1'b0;
            clear_status_o <= 1'b0;
            resume_o <= 1'b0;
            soft_reset_o <= 1'b0;
        end else begin
            dat_o <= dat_nxt;
            ack_o <= ack_nxt;
            dummy_busy_r <= dummy_busy_nxt;
            dummy_cnt_r <= dummy_cnt_nxt;
            sck_d_r <= sck_s;
            dummy_done_o <= done_nxt;
            ready_o <= (state_nxt == ST_RUN);
            addr_bytes_o <= f2.address_length_sel ? `ADDR_BYTES_4 : `ADDR_BYTES_3; // RQ1
            four_wire_o <= f2.four_wire_protocol_sel; // RQ2
            quad_width_o <= layout_v[`QUAD_BIT]; // RQ21
            line2_data_o <= quad_any ? wp_n_s : 1'b1; // RQ3
            line3_data_o <= quad_any ? line3_s : 1'b1; // RQ3
            write_protect_n_o <= quad_any ? 1'b1 : wp_n_s;
            hw_reset_o <= line3_low_nxt & ~line3_low_r;
            erase_blank_check_o <= f3.erase_blank_check; // RQ14
            pbuf_mask_o <= f3.program_buffer_size ? `PBUF_MASK_512 : `PBUF_MASK_256; // RQ15
            uniform_sectors_o <= f3.sector_layout_sel; // RQ16
            small_sector_top_o <= layout_v[`SMALL_LOC_BIT]; // RQ22
            small_sector_split_o <= layout_v[`SMALL_SPLIT_BIT];
            erase4k_go_o <= run_cmd && cmd_opcode_i == `OP_ERASE_4K && !f3.sector_layout_sel; // RQ17
            clear_status_o <= run_cmd && cmd_opcode_i == `OP_CMD30 && !f3.cmd30_function_sel; // RQ18
            resume_o <= run_cmd && cmd_opcode_i == `OP_CMD30 && f3.cmd30_function_sel; // RQ18
            soft_reset_o <= soft_hit;
        end
    end
endmodule : flash_interface_config_regs

// File: logic/flash_cfg_params.svh
// constants for the flash interface configuration register bank
`ifndef FLASH_CFG_PARAMS_SVH
`define FLASH_CFG_PARAMS_SVH

// ----------------------------------------
// wishbone byte offsets
// ----------------------------------------
`define OFS_LAYOUT_NV 8'h00
`define OFS_LAYOUT_V 8'h04
`define OFS_IFLAT_NV 8'h08
`define OFS_IFLAT_V 8'h0c
`define OFS_TRBEH_NV 8'h10
`define OFS_TRBEH_V 8'h14
`define OFS_STATUS 8'h18

// ----------------------------------------
// factory defaults and write masks
// ----------------------------------------
`define LAYOUT_RESET 8'h00
`define LAYOUT_NV_WMASK 8'h46
`define LAYOUT_V_WMASK 8'h02
`define IFLAT_RESET 8'h08
`define IFLAT_NV_WMASK 8'hef
`define IFLAT_V_WMASK 8'hef
`define TRBEH_RESET 8'h00
`define TRBEH_NV_WMASK 8'hfd
`define TRBEH_V_WMASK 8'hf5

// ----------------------------------------
// field positions
// ----------------------------------------
`define QUAD_BIT 1
`define SMALL_LOC_BIT 2
`define SMALL_SPLIT_BIT 6

// ----------------------------------------
// opcodes and fixed latencies
// ----------------------------------------
`define OP_ERASE_4K 8'h20
`define OP_CMD30 8'h30
`define OP_SOFT_RESET 8'hf0
`define SFDP_DUMMY 6'd8
`define UID_DUMMY 6'd32
`define ADDR_BYTES_3 3'd3
`define ADDR_BYTES_4 3'd4
`define PBUF_MASK_256 9'h0ff
`define PBUF_MASK_512 9'h1ff

`endif

// File: logic/flash_cfg_pkg.sv
// types shared by the flash configuration register bank
package flash_cfg_pkg;

    typedef enum logic [2:0] {
        RD_ARRAY,
        RD_NV_REG,
        RD_VOL_REG,
        RD_SFDP,
        RD_UID
    } read_class_e;

    typedef struct packed {
        logic address_length_sel;
        logic four_wire_protocol_sel;
        logic line3_reset_enable;
        logic rsvd;
        logic [3:0] array_read_latency;
    } iflat_s;

    typedef struct packed {
        logic [1:0] volatile_reg_latency;
        logic erase_blank_check;
        logic program_buffer_size;
        logic sector_layout_sel;
        logic cmd30_function_sel;
        logic rsvd;
        logic legacy_soft_reset_enable;
    } trbeh_s;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
    } cmd_s;

endpackage : flash_cfg_pkg

// File: logic/pin_sync.sv
// two-flop synchroniser for asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    always_comb begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= INIT;
            sync_o <= INIT;
        end else begin
            meta_r <= meta_nxt;
            sync_o <= sync_nxt;
        end
    end
endmodule : pin_sync

// File: logic/cfg_reg_pair.sv
// nonvolatile and volatile copy of one 8-bit configuration register
`timescale 1ns/10ps
module cfg_reg_pair #(
    parameter logic [7:0] NV_RESET = 8'h00,
    parameter logic [7:0] NV_WMASK = 8'hff,
    parameter logic [7:0] V_WMASK = 8'hff
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // access
    input wire logic nv_we_i,
    input wire logic v_we_i,
    input wire logic load_i,
    input wire logic [7:0] wdata_i,
    // copies
    output logic [7:0] nv_o,
    output logic [7:0] v_o
);
    logic [7:0] nv_nxt;
    logic [7:0] v_nxt;

    // masked-out bits keep their value, so reserved bits stay at zero
    always_comb begin
        nv_nxt = nv_o;
        v_nxt = v_o;
        if (nv_we_i) begin
            nv_nxt = (nv_o & ~NV_WMASK) | (wdata_i & NV_WMASK);
        end
        if (load_i) begin
            v_nxt = nv_o; // RQ23
        end else if (v_we_i) begin
            v_nxt = (v_o & ~V_WMASK) | (wdata_i & V_WMASK);
        end
    end

    // rst_i stands for power-up: only then does the nonvolatile copy return to default
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nv_o <= NV_RESET;
            v_o <= NV_RESET;
        end else begin
            nv_o <= nv_nxt;
            v_o <= v_nxt;
        end
    end
endmodule : cfg_reg_pair

// File: dv/cfg_regs_checker.sv
// concurrent assertions on the configuration register bank ports
`timescale 1ns/10ps
module cfg_regs_checker (
    // clock and reset
    input logic clk_i,
    input logic rst_i,
    // bus
    input logic cyc_i,
    input logic stb_i,
    input logic ack_o,
    // commands and pins
    input logic cmd_valid_i,
    input logic [7:0] cmd_opcode_i,
    input logic line3_reset_pin_i,
    // controls and events
    input logic ready_o,
    input logic [2:0] addr_bytes_o,
    input logic four_wire_o,
    input logic quad_width_o,
    input logic line2_data_o,
    input logic write_protect_n_o,
    input logic hw_reset_o,
    input logic [8:0] pbuf_mask_o,
    input logic uniform_sectors_o,
    input logic erase4k_go_o,
    input logic clear_status_o,
    input logic resume_o,
    input logic soft_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not acknowledged next cycle");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    chk_addr_len: assert property (addr_bytes_o == 3'h3 || addr_bytes_o == 3'h4)
        else $error("address length neither 3 nor 4");
    chk_pbuf_size: assert property (pbuf_mask_o == 9'h0ff || pbuf_mask_o == 9'h1ff)
        else $error("program buffer mask illegal");
    chk_plain_lines: assert property ((!four_wire_o && !quad_width_o) [*2] |-> line2_data_o)
        else $error("data line 2 active outside four-bit mode");
    chk_wp_mux: assert property ((four_wire_o || quad_width_o) [*2] |-> write_protect_n_o)
        else $error("write protect active in four-bit mode");
    chk_erase_go: assert property (cmd_valid_i && ready_o && cmd_opcode_i == 8'h20 && !uniform_sectors_o
        |-> ##[1:2] erase4k_go_o)
        else $error("small sector erase not started");
    chk_erase_block: assert property (erase4k_go_o |-> !uniform_sectors_o)
        else $error("small sector erase in uniform layout");
    chk_cmd30_excl: assert property (!(clear_status_o && resume_o))
        else $error("clear and resume together");
    chk_pin_reset: assert property ($fell(line3_reset_pin_i) && ready_o && !four_wire_o && !quad_width_o
        |-> ##[2:4] hw_reset_o)
        else $error("dedicated reset pin ignored");
    chk_reload_ready: assert property (soft_reset_o || hw_reset_o |-> ##[0:3] !ready_o)
        else $error("no reload after reset event");
    chk_ready_rise: assert property ($fell(rst_i) |-> ##[1:3] ready_o)
        else $error("ready late after reset");
    chk_soft_pulse: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset pulse too long");

    cov_erase: cover property (erase4k_go_o);
    cov_hw_reset: cover property (hw_reset_o);
    cov_resume: cover property (resume_o);
    cov_soft: cover property (soft_reset_o);
endmodule : cfg_regs_checker

bind flash_interface_config_regs cfg_regs_checker chk (.*);

// File: dv/flash_host_model.sv
// serial host controller model: chip select and serial clock
`timescale 1ns/10ps
module flash_host_model (
    // serial pins
    output logic sck_o,
    output logic cs_n_o
);
    // clock idles low outside frames; phase unrelated to the system clock
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
    end
    task automatic open_frame();
        #3 cs_n_o = 1'b0;
    endtask : open_frame
    // 160 ns period, far below the single and double rate ceilings
    task automatic clocks(input int n);
        // keeps serial edges off the system clock edges
        #7;
        repeat (n) begin
            #80 sck_o = 1'b1;
            #80 sck_o = 1'b0;
        end
    endtask : clocks
    task automatic close_frame();
        #45 cs_n_o = 1'b1;
    endtask : close_frame
endmodule : flash_host_model

// File: dv/flash_interface_config_regs_tb_top.sv
// self-checking bench of the configuration register bank
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module flash_interface_config_regs_tb_top
    import flash_cfg_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, cmd_valid_i = 1'b0;
    logic dummy_start_i = 1'b0, wp_n_i = 1'b1, line3_reset_pin_i = 1'b1, sck_i, cs_n_i;
    logic [7:0] adr_i = 8'h00, cmd_opcode_i = 8'h00, d, t;
    logic [3:0] sel_i = 4'h1, mode_cycles_i = 4'h0, lat;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    read_class_e read_class_i = RD_ARRAY;
    logic ack_o, ready_o, four_wire_o, quad_width_o, line2_data_o, line3_data_o, write_protect_n_o, hw_reset_o;
    logic erase_blank_check_o, uniform_sectors_o, small_sector_top_o, erase4k_go_o, clear_status_o, resume_o;
    logic soft_reset_o, dummy_done_o, small_sector_split_o;
    logic [2:0] addr_bytes_o;
    logic [8:0] pbuf_mask_o;
    logic [5:0] ev;
    logic [15:0] lfsr = 16'h57e6;
    logic [7:0] dflt_a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
    logic [7:0] dflt_v [7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00};
    int mismatches = 0, check_count = 0, n;
    int cnt [6];

    flash_interface_config_regs uut (.*);
    flash_host_model host (.sck_o(sck_i), .cs_n_o(cs_n_i));

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // event counters and helpers
    // ----------------------------------------
    assign ev = {dummy_done_o, hw_reset_o, soft_reset_o, resume_o, clear_status_o, erase4k_go_o};
    always @(posedge clk_i) begin
        for (int i = 0; i < 6; i++) if (ev[i] === 1'b1) cnt[i]++;
    end
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    // mode cycles come first and are not part of the latency
    function automatic int exp_dummy(read_class_e c, logic [3:0] l, logic [1:0] v, logic [3:0] m);
        case (c)
            RD_ARRAY, RD_NV_REG: return int'(l) + int'(m);
            RD_VOL_REG: return (v == 2'h0 ? 0 : v == 2'h3 ? 2 : 1) + int'(m);
            RD_SFDP: return 8 + int'(m);
            default: return 32 + int'(m);
        endcase
    endfunction : exp_dummy
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dd, input logic s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, dd};
        sel_i <= {3'h0, s};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] dd);
        wb(1'b1, a, dd, 1'b1);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00, 1'b1);
        `CHK(nm, {24'h000000, e}, q)
    endtask : rd_chk
    task automatic cmd(input logic [7:0] op);
        while (ready_o !== 1'b1) @(posedge clk_i);
        cnt = '{default: 0};
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_opcode_i <= op;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : cmd
    task automatic dum(input read_class_e c, input logic [3:0] m, input int edges, input int e);
        host.open_frame();
        repeat (3) @(posedge clk_i);
        cnt[5] = 0;
        dummy_start_i <= 1'b1;
        read_class_i <= c;
        mode_cycles_i <= m;
        @(posedge clk_i);
        dummy_start_i <= 1'b0;
        host.clocks(edges);
        repeat (10) @(posedge clk_i);
        `CHK("dummy_done", e, cnt[5])
        if (e == 1) host.clocks(16);
        host.close_frame();
    endtask : dum
    task automatic pin_low(input int e);
        line3_reset_pin_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        `CHK("hw_reset", e, cnt[4])
        line3_reset_pin_i <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask : pin_low
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        foreach (dflt_a[i]) rd_chk("reg_default", dflt_a[i], dflt_v[i]);
        `CHK("pbuf", 9'h0ff, pbuf_mask_o)
        repeat (4) begin
            d = rnd() & 8'hef;
            t = rnd() & 8'hf5;
            wr(8'h0c, d);
            wr(8'h14, t);
            rd_chk("iflat_vol", 8'h0c, d);
            rd_chk("trbeh_vol", 8'h14, t);
            `CHK("addr_bytes", d[7] ? 3'h4 : 3'h3, addr_bytes_o)
            `CHK("four_wire", d[6], four_wire_o)
            `CHK("pbuf", t[4] ? 9'h1ff : 9'h0ff, pbuf_mask_o)
            `CHK("blank_check", t[5], erase_blank_check_o)
        end
        wb(1'b1, 8'h0c, ~d, 1'b0);
        rd_chk("sel_ignored", 8'h0c, d);
        wr(8'h0c, 8'h00);
        wr(8'h14, 8'h00);
        cmd(8'h20);
        `CHK("erase4k", 1, cnt[0])
        cmd(8'h30);
        `CHK("clear_status", 1, cnt[1] + cnt[2] * 2)
        wr(8'h14, 8'h04);
        cmd(8'h30);
        `CHK("resume", 2, cnt[1] + cnt[2] * 2)
        cmd(8'hf0);
        `CHK("soft_off", 0, cnt[3])
        wr(8'h10, 8'h09);
        wr(8'h00, 8'h44);
        wr(8'h08, 8'h8a);
        wr(8'h14, 8'h05);
        cmd(8'hf0);
        `CHK("soft_on", 1, cnt[3])
        rd_chk("reload_iflat", 8'h0c, 8'h8a);
        rd_chk("reload_trbeh", 8'h14, 8'h09);
        `CHK("uniform", 1'b1, uniform_sectors_o)
        `CHK("small_top", 1'b1, small_sector_top_o)
        `CHK("small_split", 1'b1, small_sector_split_o)
        `CHK("addr_bytes", 3'h4, addr_bytes_o)
        cmd(8'h20);
        `CHK("erase4k_off", 0, cnt[0])
        wr(8'h14, 8'h01);
        rd_chk("layout_ro", 8'h14, 8'h09);
        for (int i = 0; i < 5; i++) begin
            d = rnd();
            lat = (i == 0) ? 4'hf : d[3:0];
            wr(8'h0c, {4'h0, lat});
            wr(8'h14, {d[7:6], 6'h00});
            n = exp_dummy(read_class_e'(i), lat, d[7:6], {2'h0, d[5:4]});
            dum(read_class_e'(i), {2'h0, d[5:4]}, n, 1);
            if (n > 0) dum(read_class_e'(i), {2'h0, d[5:4]}, n - 1, 0);
        end
        cnt = '{default: 0};
        wr(8'h0c, 8'h08);
        wp_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK("wp_plain", 1'b0, write_protect_n_o)
        pin_low(1);
        wr(8'h0c, 8'h48);
        pin_low(1);
        line3_reset_pin_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK("line2", 1'b0, line2_data_o)
        `CHK("line3", 1'b0, line3_data_o)
        `CHK("wp_quad", 1'b1, write_protect_n_o)
        line3_reset_pin_i <= 1'b1;
        wr(8'h0c, 8'h68);
        host.open_frame();
        pin_low(1);
        host.close_frame();
        pin_low(2);
        `CHK("reloaded_mode", 1'b0, four_wire_o)
        wr(8'h04, 8'h02);
        rd_chk("layout_vol", 8'h04, 8'h46);
        repeat (4) @(posedge clk_i);
        `CHK("quad_width", 1'b1, quad_width_o)
        `CHK("quad_line2", 1'b0, line2_data_o)
        complete_run();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end
endmodule : flash_interface_config_regs_tb_top
